// File: shared/dsa_pkg.sv
// Package with object indices, reset values, option codes and state carriers of the stop action block.
package dsa_pkg;

  localparam logic [15:0] IDX_SPEED_SCALE = 16'h604C;
  localparam logic [15:0] IDX_QS_ACTION   = 16'h605A;
  localparam logic [15:0] IDX_SD_ACTION   = 16'h605B;
  localparam logic [15:0] IDX_DIS_ACTION  = 16'h605C;

  localparam logic [7:0]  SUB_COUNT = 8'h00;
  localparam logic [7:0]  SUB_NUM   = 8'h01;
  localparam logic [7:0]  SUB_DEN   = 8'h02;
  localparam logic [7:0]  SCALE_SUB_MAX = 8'h02;

  localparam logic [31:0] NUM_RST = 32'h0000_0001;
  localparam logic [31:0] DEN_RST = 32'h0000_0001;
  localparam logic [15:0] QS_RST  = 16'h0002;
  localparam logic [15:0] SD_RST  = 16'h0001;
  localparam logic [15:0] DIS_RST = 16'h0001;

  localparam logic [15:0] QS_IMMEDIATE  = 16'h0000;
  localparam logic [15:0] QS_SLOW_SOD   = 16'h0001;
  localparam logic [15:0] QS_QUICK_SOD  = 16'h0002;
  localparam logic [15:0] QS_SLOW_HOLD  = 16'h0005;
  localparam logic [15:0] QS_QUICK_HOLD = 16'h0006;
  localparam logic [15:0] OFF_COAST     = 16'h0000;
  localparam logic [15:0] OFF_SLOW_SOD  = 16'h0001;

  localparam logic [6:0]  DIV_LAST = 7'h3F;

  typedef enum logic [1:0] {
    DSA_IDLE = 2'b00,
    DSA_RAMP = 2'b01,
    DSA_HOLD = 2'b10
  } dsa_seq_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } dsa_obj_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dsa_obj_rsp_t;

  typedef struct packed {
    logic coast;
    logic quick_halt;
    logic brake_slow;
    logic brake_quick;
    logic hold_energized;
    logic to_sod;
  } dsa_cmd_t;

  typedef struct packed {
    logic [31:0]  num;
    logic [31:0]  den;
    logic [15:0]  qs_code;
    logic [15:0]  sd_code;
    logic [15:0]  dis_code;
    dsa_seq_t     seq;
    logic         after_sod;
    dsa_cmd_t     cmd;
    dsa_obj_rsp_t rsp;
  } dsa_core_st_t;

  typedef struct packed {
    logic        busy;
    logic        neg;
    logic [6:0]  cnt;
    logic [63:0] quo;
    logic [32:0] rem;
    logic [31:0] dvs;
    logic [31:0] result;
    logic        done;
    logic        div_zero;
  } dsa_div_st_t;

endpackage

// File: core/dsa_speed_scale.sv
// Sequential speed scaler: internal speed times numerator, divided by denominator.
module dsa_speed_scale (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [31:0] speed_in,
  input  wire logic [31:0] num,
  input  wire logic [31:0] den,
  output logic             busy,
  output logic             done,
  output logic             div_zero,
  output logic [31:0]      rpm_out
);

  dsa_pkg::dsa_div_st_t st_ff;
  dsa_pkg::dsa_div_st_t nxt_st;

  always_comb
  begin
    logic signed [63:0] prod;
    logic [32:0]        rem_sh;
    logic [63:0]        quo_sh;
    prod   = $signed({{32{speed_in[31]}}, speed_in}) * $signed({{32{num[31]}}, num});
    rem_sh = {st_ff.rem[31:0], st_ff.quo[63]};
    quo_sh = {st_ff.quo[62:0], 1'b0};
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.busy)
    begin
      if (rem_sh >= {1'b0, st_ff.dvs})
      begin
        rem_sh    = rem_sh - {1'b0, st_ff.dvs};
        quo_sh[0] = 1'b1;
      end
      nxt_st.rem = rem_sh;
      nxt_st.quo = quo_sh;
      nxt_st.cnt = st_ff.cnt + 7'h01;
      if (st_ff.cnt == dsa_pkg::DIV_LAST)
      begin
        nxt_st.busy   = 1'b0;
        nxt_st.done   = 1'b1;
        nxt_st.result = st_ff.neg ? 32'(-quo_sh[31:0]) : quo_sh[31:0];
      end
    end
    else if (start)
    begin
      // A zero divisor would run the loop to a meaningless all-ones quotient, so it answers at once with zero.
      if (den == 32'h0000_0000)
      begin
        nxt_st.done     = 1'b1;
        nxt_st.div_zero = 1'b1;
        nxt_st.result   = 32'h0000_0000;
      end
      else
      begin
        nxt_st.div_zero = 1'b0;
        nxt_st.busy     = 1'b1;
        nxt_st.cnt      = 7'h00;
        nxt_st.rem      = 33'h0_0000_0000;
        nxt_st.neg      = prod[63] ^ den[31];
        nxt_st.quo      = prod[63] ? 64'(-prod) : 64'(prod);
        nxt_st.dvs      = den[31] ? 32'(-den) : den;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy     = st_ff.busy;
  assign done     = st_ff.done;
  assign div_zero = st_ff.div_zero;
  assign rpm_out  = st_ff.result;

  zero_div_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && start && !st_ff.busy && den == 32'h0000_0000) |=> (done && div_zero && rpm_out == 32'h0000_0000))
    else $error("Zero divisor did not answer at once with zero.");

endmodule // dsa_speed_scale

// File: core/dsa_stop_select.sv
// Stop action select block: option code objects, stop sequencer and speed scaling.
// Overview of operation
// - Speed in rpm equals internal speed times numerator divided by denominator.
// - Numerator and denominator reset to one, signed 32-bit, readable and writable.
// - Quick stop code applies on entry to quick stop active; resets to 2.
// - Quick stop code 0 stops at once, then goes to switch on disabled.
// - Quick stop code 1 brakes on slow-down ramp, then switch on disabled.
// - Quick stop code 2 brakes on quick stop ramp, then switch on disabled.
// - Quick stop code 5 brakes slow, stays in quick stop, energized.
// - Quick stop code 6 brakes quick, stays in quick stop, energized.
// - Shutdown code applies from operation enabled to ready; resets to 1.
// - Disable code applies from operation enabled to switched on; resets to 1.
// - Shutdown or disable code 0 blocks the drive so the motor coasts.
// - Shutdown or disable code 1 brakes slow, then switch on disabled.
module dsa_stop_select (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire dsa_pkg::dsa_obj_req_t obj_req,
  output dsa_pkg::dsa_obj_rsp_t      obj_rsp,
  input  wire logic                  qs_enter,
  input  wire logic                  shutdown_trans,
  input  wire logic                  disable_trans,
  input  wire logic                  standstill,
  input  wire logic                  psm_clear,
  output dsa_pkg::dsa_cmd_t          stop_cmd,
  input  wire logic                  speed_req,
  input  wire logic [31:0]           speed_int,
  output logic                       speed_busy,
  output logic                       speed_valid,
  output logic                       speed_div_zero,
  output logic [31:0]                speed_rpm
);

  dsa_pkg::dsa_core_st_t st_ff;
  dsa_pkg::dsa_core_st_t nxt_st;

  function automatic logic qs_code_ok(input logic [15:0] code);
    return code == dsa_pkg::QS_IMMEDIATE || code == dsa_pkg::QS_SLOW_SOD || code == dsa_pkg::QS_QUICK_SOD
        || code == dsa_pkg::QS_SLOW_HOLD || code == dsa_pkg::QS_QUICK_HOLD;
  endfunction

  function automatic logic off_code_ok(input logic [31:0] wdata);
    return wdata[15:0] == dsa_pkg::OFF_COAST || wdata[15:0] == dsa_pkg::OFF_SLOW_SOD;
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  always_comb
  begin
    logic [15:0] off_code;
    off_code = 16'h0000;
    nxt_st = st_ff;

    // Object access: every request is answered one cycle later.
    nxt_st.rsp.ack = obj_req.wr | obj_req.rd;
    nxt_st.rsp.err = 1'b0;
    if (obj_req.wr)
    begin
      case (obj_req.index)
        dsa_pkg::IDX_SPEED_SCALE:
        begin
          if (obj_req.sub == dsa_pkg::SUB_NUM)
            nxt_st.num = obj_req.wdata;
          else if (obj_req.sub == dsa_pkg::SUB_DEN)
            nxt_st.den = obj_req.wdata;
          else
            nxt_st.rsp.err = 1'b1;
        end
        dsa_pkg::IDX_QS_ACTION:
        begin
          // A 32-bit write must sign-extend a 16-bit value, else it is not that value.
          if (obj_req.sub == dsa_pkg::SUB_COUNT && obj_req.wdata == sext16(obj_req.wdata[15:0])
              && qs_code_ok(obj_req.wdata[15:0]))
            nxt_st.qs_code = obj_req.wdata[15:0];
          else
            nxt_st.rsp.err = 1'b1;
        end
        dsa_pkg::IDX_SD_ACTION:
        begin
          if (obj_req.sub == dsa_pkg::SUB_COUNT && obj_req.wdata[31:16] == 16'h0000 && off_code_ok(obj_req.wdata))
            nxt_st.sd_code = obj_req.wdata[15:0];
          else
            nxt_st.rsp.err = 1'b1;
        end
        dsa_pkg::IDX_DIS_ACTION:
        begin
          if (obj_req.sub == dsa_pkg::SUB_COUNT && obj_req.wdata[31:16] == 16'h0000 && off_code_ok(obj_req.wdata))
            nxt_st.dis_code = obj_req.wdata[15:0];
          else
            nxt_st.rsp.err = 1'b1;
        end
        default:
        begin
          nxt_st.rsp.err = 1'b1;
        end
      endcase
    end
    else if (obj_req.rd)
    begin
      nxt_st.rsp.rdata = 32'h0000_0000;
      case (obj_req.index)
        dsa_pkg::IDX_SPEED_SCALE:
        begin
          if (obj_req.sub == dsa_pkg::SUB_COUNT)
            nxt_st.rsp.rdata = {24'h00_0000, dsa_pkg::SCALE_SUB_MAX};
          else if (obj_req.sub == dsa_pkg::SUB_NUM)
            nxt_st.rsp.rdata = st_ff.num;
          else if (obj_req.sub == dsa_pkg::SUB_DEN)
            nxt_st.rsp.rdata = st_ff.den;
          else
            nxt_st.rsp.err = 1'b1;
        end
        dsa_pkg::IDX_QS_ACTION:
        begin
          nxt_st.rsp.rdata = sext16(st_ff.qs_code);
          nxt_st.rsp.err   = obj_req.sub != dsa_pkg::SUB_COUNT;
        end
        dsa_pkg::IDX_SD_ACTION:
        begin
          nxt_st.rsp.rdata = sext16(st_ff.sd_code);
          nxt_st.rsp.err   = obj_req.sub != dsa_pkg::SUB_COUNT;
        end
        dsa_pkg::IDX_DIS_ACTION:
        begin
          nxt_st.rsp.rdata = sext16(st_ff.dis_code);
          nxt_st.rsp.err   = obj_req.sub != dsa_pkg::SUB_COUNT;
        end
        default:
        begin
          nxt_st.rsp.err = 1'b1;
        end
      endcase
    end

    // Stop sequencer: progress of the running stop.
    nxt_st.cmd.to_sod = 1'b0;
    case (st_ff.seq)
      dsa_pkg::DSA_IDLE:
      begin
        nxt_st.cmd = '0;
      end
      dsa_pkg::DSA_RAMP:
      begin
        if (standstill)
        begin
          nxt_st.cmd.quick_halt  = 1'b0;
          nxt_st.cmd.brake_slow  = 1'b0;
          nxt_st.cmd.brake_quick = 1'b0;
          if (st_ff.after_sod)
          begin
            nxt_st.cmd.to_sod         = 1'b1;
            nxt_st.cmd.hold_energized = 1'b0;
            nxt_st.seq                = dsa_pkg::DSA_IDLE;
          end
          else
          begin
            nxt_st.seq = dsa_pkg::DSA_HOLD;
          end
        end
      end
      dsa_pkg::DSA_HOLD:
      begin
        // Held until the power state machine leaves the stop state, e.g. back to operation enabled.
        if (psm_clear)
        begin
          nxt_st.cmd = '0;
          nxt_st.seq = dsa_pkg::DSA_IDLE;
        end
      end
      default:
      begin
        nxt_st.cmd = '0;
        nxt_st.seq = dsa_pkg::DSA_IDLE;
      end
    endcase

    // A new transition restarts the sequence; quick stop has priority over the other two.
    if (qs_enter)
    begin
      nxt_st.cmd       = '0;
      nxt_st.seq       = dsa_pkg::DSA_RAMP;
      nxt_st.after_sod = 1'b1;
      case (st_ff.qs_code)
        dsa_pkg::QS_IMMEDIATE:  nxt_st.cmd.quick_halt = 1'b1;
        dsa_pkg::QS_SLOW_SOD:   nxt_st.cmd.brake_slow = 1'b1;
        dsa_pkg::QS_QUICK_SOD:  nxt_st.cmd.brake_quick = 1'b1;
        dsa_pkg::QS_SLOW_HOLD:
        begin
          nxt_st.cmd.brake_slow     = 1'b1;
          nxt_st.cmd.hold_energized = 1'b1;
          nxt_st.after_sod          = 1'b0;
        end
        dsa_pkg::QS_QUICK_HOLD:
        begin
          nxt_st.cmd.brake_quick    = 1'b1;
          nxt_st.cmd.hold_energized = 1'b1;
          nxt_st.after_sod          = 1'b0;
        end
        default:                nxt_st.cmd.brake_quick = 1'b1;
      endcase
    end
    else if (shutdown_trans || disable_trans)
    begin
      off_code         = shutdown_trans ? st_ff.sd_code : st_ff.dis_code;
      nxt_st.cmd       = '0;
      nxt_st.after_sod = 1'b1;
      if (off_code == dsa_pkg::OFF_COAST)
      begin
        nxt_st.cmd.coast = 1'b1;
        nxt_st.seq       = dsa_pkg::DSA_HOLD;
      end
      else
      begin
        nxt_st.cmd.brake_slow = 1'b1;
        nxt_st.seq            = dsa_pkg::DSA_RAMP;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      st_ff          <= '0;
      st_ff.num      <= dsa_pkg::NUM_RST;
      st_ff.den      <= dsa_pkg::DEN_RST;
      st_ff.qs_code  <= dsa_pkg::QS_RST;
      st_ff.sd_code  <= dsa_pkg::SD_RST;
      st_ff.dis_code <= dsa_pkg::DIS_RST;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  assign obj_rsp  = st_ff.rsp;
  assign stop_cmd = st_ff.cmd;

  // The product is taken at the request, so later scaling writes do not disturb a running division.
  dsa_speed_scale u_scale (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .start    (speed_req),
    .speed_in (speed_int),
    .num      (st_ff.num),
    .den      (st_ff.den),
    .busy     (speed_busy),
    .done     (speed_valid),
    .div_zero (speed_div_zero),
    .rpm_out  (speed_rpm)
  );

  reset_vals_a: assert property (@(posedge core_clk) (!reset_n && clk_en) |=>
    (st_ff.num == dsa_pkg::NUM_RST && st_ff.den == dsa_pkg::DEN_RST && st_ff.qs_code == dsa_pkg::QS_RST
     && st_ff.sd_code == dsa_pkg::SD_RST && st_ff.dis_code == dsa_pkg::DIS_RST))
    else $error("Preset values not loaded by reset.");

  qs_immediate_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && qs_enter && st_ff.qs_code == dsa_pkg::QS_IMMEDIATE) |=> (stop_cmd.quick_halt && !stop_cmd.brake_slow))
    else $error("Quick stop code 0 did not halt at once.");

  qs_slow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && qs_enter && st_ff.qs_code == dsa_pkg::QS_SLOW_SOD) |=> (stop_cmd.brake_slow && st_ff.after_sod))
    else $error("Quick stop code 1 did not brake on the slow ramp.");

  qs_quick_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && qs_enter && st_ff.qs_code == dsa_pkg::QS_QUICK_SOD) |=> (stop_cmd.brake_quick && !stop_cmd.brake_slow))
    else $error("Quick stop code 2 did not brake on the quick ramp.");

  hold_energized_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && st_ff.seq == dsa_pkg::DSA_RAMP && !st_ff.after_sod && standstill && !qs_enter && !shutdown_trans
     && !disable_trans) |=> (st_ff.seq == dsa_pkg::DSA_HOLD && stop_cmd.hold_energized && !stop_cmd.to_sod))
    else $error("Holding quick stop did not keep the motor energized.");

  slow_sod_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && shutdown_trans && !qs_enter && st_ff.sd_code == dsa_pkg::OFF_SLOW_SOD) ##1
    (clk_en && standstill && !qs_enter && !shutdown_trans && !disable_trans) |=> (stop_cmd.to_sod && !stop_cmd.brake_slow))
    else $error("Slow ramp stop did not end in switch on disabled.");

  coast_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && disable_trans && !shutdown_trans && !qs_enter && st_ff.dis_code == dsa_pkg::OFF_COAST) |=>
    (stop_cmd.coast && !stop_cmd.brake_slow && !stop_cmd.brake_quick))
    else $error("Code 0 did not block the drive.");

  bad_code_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clk_en && obj_req.wr && obj_req.index == dsa_pkg::IDX_QS_ACTION && !qs_code_ok(obj_req.wdata[15:0])) |=>
    (obj_rsp.ack && obj_rsp.err && $stable(st_ff.qs_code)))
    else $error("Undefined quick stop code was taken.");

endmodule // dsa_stop_select

// File: testbench/dsa_master_model.sv
// Fieldbus master model that issues object reads and writes.
module dsa_master_model (
  input  wire logic                  core_clk,
  input  wire dsa_pkg::dsa_obj_rsp_t obj_rsp,
  output dsa_pkg::dsa_obj_req_t      obj_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial obj_req = '0;

  // The strobe lasts one cycle; index and data are then inverted so that a stale bus cannot match.
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd,
                        input int gap, output logic err, output logic [31:0] rd);
    int n;
    repeat (gap) @(negedge core_clk);
    obj_req = {w, ~w, idx, sb, wd};
    @(negedge core_clk);
    obj_req = {2'b00, ~idx, ~sb, ~wd};
    n = 0;
    while (obj_rsp.ack !== 1'b1 && n < 4)
    begin
      @(negedge core_clk);
      n++;
    end
    err = obj_rsp.ack ? obj_rsp.err : 1'bx;
    rd = obj_rsp.rdata;
  endtask
endmodule // dsa_master_model

// File: testbench/tb_dsa_stop_select.sv
// Self-checking bench of the stop action select block.
module tb_dsa_stop_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  clk_en = 1'b1;
  dsa_pkg::dsa_obj_req_t obj_req;
  dsa_pkg::dsa_obj_rsp_t obj_rsp;
  logic                  qs_enter = 1'b0;
  logic                  shutdown_trans = 1'b0;
  logic                  disable_trans = 1'b0;
  logic                  standstill = 1'b0;
  logic                  psm_clear = 1'b0;
  dsa_pkg::dsa_cmd_t     stop_cmd;
  logic                  speed_req = 1'b0;
  logic [31:0]           speed_int = 32'h0;
  logic                  speed_busy;
  logic                  speed_valid;
  logic                  speed_div_zero;
  logic [31:0]           speed_rpm;
  logic [31:0]           a;
  logic [31:0]           b;
  logic [31:0]           r;
  int                    error_cnt = 0;
  int                    compares = 0;
  int                    seed = 32'hFD84F528;

  dsa_stop_select u_dsa_stop_select (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .qs_enter(qs_enter), .shutdown_trans(shutdown_trans), .disable_trans(disable_trans),
    .standstill(standstill), .psm_clear(psm_clear), .stop_cmd(stop_cmd), .speed_req(speed_req),
    .speed_int(speed_int), .speed_busy(speed_busy), .speed_valid(speed_valid),
    .speed_div_zero(speed_div_zero), .speed_rpm(speed_rpm));

  dsa_master_model u_dsa_master_model (.core_clk(core_clk), .obj_rsp(obj_rsp), .obj_req(obj_req));

  always #5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_cmd(input dsa_pkg::dsa_cmd_t exp, input dsa_pkg::dsa_cmd_t got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd,
                     input logic exp_err, output logic [31:0] rd);
    logic e;
    // At least one idle edge between requests, so the strobe is never lowered and raised in one step.
    u_dsa_master_model.access(w, idx, sb, wd, 1 + {$random(seed)} % 3, e, rd);
    chk(32'(exp_err), 32'(e));
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] exp);
    logic [31:0] v;
    obj(1'b0, idx, sb, 32'h0, 1'b0, v);
    chk(exp, v);
  endtask

  function automatic dsa_pkg::dsa_cmd_t exp_cmd(input logic q, input logic [15:0] code, input logic aft);
    dsa_pkg::dsa_cmd_t c;
    c = '0;
    if (q)
    begin
      c.quick_halt = !aft && code == dsa_pkg::QS_IMMEDIATE;
      c.brake_slow = !aft && (code == dsa_pkg::QS_SLOW_SOD || code == dsa_pkg::QS_SLOW_HOLD);
      c.brake_quick = !aft && (code == dsa_pkg::QS_QUICK_SOD || code == dsa_pkg::QS_QUICK_HOLD);
      c.hold_energized = code > 16'h0004;
      c.to_sod = aft && code < 16'h0003;
    end
    else
    begin
      c.coast = code == dsa_pkg::OFF_COAST;
      c.brake_slow = !aft && code == dsa_pkg::OFF_SLOW_SOD;
      c.to_sod = aft && code == dsa_pkg::OFF_SLOW_SOD;
    end
    return c;
  endfunction

  task automatic stop_case(input int ev, input logic [15:0] code);
    logic q;
    q = (ev == 0 || ev == 3);
    if (ev == 3)
      obj(1'b1, dsa_pkg::IDX_SD_ACTION, dsa_pkg::SUB_COUNT, 32'h0, 1'b0, r);
    obj(1'b1, q ? dsa_pkg::IDX_QS_ACTION : (ev == 1 ? dsa_pkg::IDX_SD_ACTION : dsa_pkg::IDX_DIS_ACTION),
        dsa_pkg::SUB_COUNT, {16'h0, code}, 1'b0, r);
    @(negedge core_clk);
    qs_enter = q;
    shutdown_trans = (ev == 1 || ev == 3);
    disable_trans = (ev == 2 || ev == 3);
    @(negedge core_clk);
    {qs_enter, shutdown_trans, disable_trans} = 3'b000;
    chk_cmd(exp_cmd(q, code, 1'b0), stop_cmd);
    repeat ({$random(seed)} % 4) @(negedge core_clk);
    standstill = 1'b1;
    @(negedge core_clk);
    standstill = 1'b0;
    chk_cmd(exp_cmd(q, code, 1'b1), stop_cmd);
    @(negedge core_clk);
    chk_cmd(exp_cmd(q, code, 1'b1) & 6'h3E, stop_cmd);
    psm_clear = 1'b1;
    @(negedge core_clk);
    psm_clear = 1'b0;
    chk_cmd('0, stop_cmd);
  endtask

  task automatic speed_case(input logic [31:0] num, input logic [31:0] den, input logic [31:0] spd);
    longint p;
    int     n;
    obj(1'b1, dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_NUM, num, 1'b0, r);
    obj(1'b1, dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_DEN, den, 1'b0, r);
    rd_chk(dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_DEN, den);
    p = longint'($signed(spd)) * longint'($signed(num));
    p = (den == 32'h0) ? 64'sh0 : p / longint'($signed(den));
    @(negedge core_clk);
    speed_req = 1'b1;
    speed_int = spd;
    @(negedge core_clk);
    speed_req = 1'b0;
    speed_int = ~spd;
    chk(32'(den != 32'h0), 32'(speed_busy));
    n = 0;
    // A second request in mid-division must be ignored and must not disturb the result.
    // Three edges with the clock enable low must stretch the division by exactly three cycles.
    while (speed_valid !== 1'b1 && n < 80)
    begin
      @(negedge core_clk);
      n++;
      speed_req = (n == 10);
      clk_en = !(n >= 20 && n < 23);
    end
    chk((den == 32'h0) ? 32'h0 : 32'(dsa_pkg::DIV_LAST) + 32'h4, 32'(n));
    chk(p[31:0], speed_rpm);
    chk(32'(den == 32'h0), 32'(speed_div_zero));
  endtask

  initial
  begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    obj(1'b1, dsa_pkg::IDX_QS_ACTION, dsa_pkg::SUB_COUNT, 32'h0000_0003, 1'b1, r);
    obj(1'b1, dsa_pkg::IDX_QS_ACTION, dsa_pkg::SUB_COUNT, 32'h0001_0005, 1'b1, r);
    obj(1'b1, dsa_pkg::IDX_SD_ACTION, dsa_pkg::SUB_COUNT, 32'h0000_0002, 1'b1, r);
    obj(1'b1, dsa_pkg::IDX_DIS_ACTION, dsa_pkg::SUB_COUNT, 32'hFFFF_FFFF, 1'b1, r);
    obj(1'b1, dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_COUNT, 32'h0000_0005, 1'b1, r);
    obj(1'b0, 16'h605D, dsa_pkg::SUB_COUNT, 32'h0, 1'b1, r);
    obj(1'b0, dsa_pkg::IDX_SPEED_SCALE, 8'h03, 32'h0, 1'b1, r);
    rd_chk(dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_NUM, dsa_pkg::NUM_RST);
    rd_chk(dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_DEN, dsa_pkg::DEN_RST);
    rd_chk(dsa_pkg::IDX_SPEED_SCALE, dsa_pkg::SUB_COUNT, {24'h0, dsa_pkg::SCALE_SUB_MAX});
    rd_chk(dsa_pkg::IDX_QS_ACTION, dsa_pkg::SUB_COUNT, {16'h0, dsa_pkg::QS_RST});
    rd_chk(dsa_pkg::IDX_SD_ACTION, dsa_pkg::SUB_COUNT, {16'h0, dsa_pkg::SD_RST});
    rd_chk(dsa_pkg::IDX_DIS_ACTION, dsa_pkg::SUB_COUNT, {16'h0, dsa_pkg::DIS_RST});
    $display("test reset_and_refusal done");
    for (int i = 0; i < 5; i++)
      stop_case(0, 16'(i < 3 ? i : i + 2));
    for (int i = 0; i < 4; i++)
      stop_case(1 + i / 2, 16'(i % 2));
    stop_case(3, dsa_pkg::QS_QUICK_HOLD);
    $display("test stop_actions done");
    for (int i = 0; i < 6; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      speed_case(i == 0 ? 32'h1 : {{16{a[15]}}, a[15:0]},
                 i == 1 ? 32'h0 : (i == 2 ? 32'hFFFF_FFFD : {16'h0, b[15:0] | 16'h0001}), $random(seed));
    end
    $display("test speed_scaling done");
    tally_and_finish();
  end

  // Ten stop cases and six scalings take well under 3000 cycles; the limit leaves ample margin.
  initial
  begin
    #300us;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_dsa_stop_select
